// *** pkg/amu_defs.vh ***
// constants for the accumulator magnitude unit
// assumes inclusion by bare name from design files
`ifndef AMU_DEFS_VH
`define AMU_DEFS_VH
`define AMU_OP_ABS 16'hff56
`define AMU_OP_MAGNITUDE_TOGGLE_SIGN_OP 16'h565f
`define AMU_MOST_NEG 32'h80000000
`define AMU_MAX_POS 32'h7fffffff
`define AMU_ACC_RESET 32'h00000000
`define AMU_SIGN_BIT 31
// status bit positions
`define AMU_EV_ABS 0
`define AMU_EV_MAGNITUDE_TOGGLE_SIGN_OP 1
`define AMU_EV_OVF 2
`define AMU_EV_RPT 3
`define AMU_EV_ILLEGAL 4
`define AMU_EV_W 5
// register indices
`define AMU_REG_ACC 4'h0
`define AMU_REG_FLAGS 4'h1
`define AMU_REG_MODE 4'h2
`define AMU_REG_RPT 4'h3
`define AMU_REG_STATUS 4'h4
`define AMU_REG_MASK 4'h5
// flags register field positions
`define AMU_F_N 0
`define AMU_F_Z 1
`define AMU_F_C 2
`define AMU_F_V 3
`define AMU_F_TC 4
`endif

// *** design/amu_decode.v ***
// opcode decoder for the two magnitude instructions
// assumes opcode and mode from logic on the same clock
`timescale 1ns/10ps
`include "amu_defs.vh"
module amu_decode
(
  // instruction
  input wire [15:0] opcode_i,
  input wire valid_i,
  input wire native_mode_i,
  // decoded
  output wire is_abs_o,
  output wire is_magnitude_toggle_sign_op_o,
  output wire illegal_o
);
  assign is_abs_o = valid_i && (opcode_i == `AMU_OP_ABS);
  assign is_magnitude_toggle_sign_op_o = valid_i && native_mode_i && (opcode_i == `AMU_OP_MAGNITUDE_TOGGLE_SIGN_OP);
  // toggling form seen outside native mode
  assign illegal_o = valid_i && !native_mode_i && (opcode_i == `AMU_OP_MAGNITUDE_TOGGLE_SIGN_OP);
endmodule // amu_decode

// *** design/amu_magnitude.v ***
// combinational magnitude and flag computation
// assumes a 32-bit accumulator input from the same clock
`timescale 1ns/10ps
`include "amu_defs.vh"
module amu_magnitude
#(
  parameter WIDTH = 32
)
(
  // operands
  input wire [WIDTH-1:0] value_i,
  input wire saturate_i,
  // result
  output reg [WIDTH-1:0] result_o,
  output wire overflow_o,
  output wire negative_in_o
);
  assign overflow_o = (value_i == `AMU_MOST_NEG);
  assign negative_in_o = value_i[WIDTH-1];
  always @*
  begin
    if (overflow_o)
      result_o = saturate_i ? `AMU_MAX_POS : `AMU_MOST_NEG;
    else if (value_i[WIDTH-1])
      result_o = ~value_i + {{(WIDTH-1){1'b0}}, 1'b1};
    else
      result_o = value_i;
  end
endmodule // amu_magnitude

// *** design/amu_top.v ***
// accumulator magnitude datapath with a register port and interrupt
// assumes instruction strobe and register port come from core-clock logic
`timescale 1ns/10ps
`include "amu_defs.vh"
module amu_top
(
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // instruction issue
  input wire INSTR_VALID_I,
  input wire [15:0] OPCODE_I,
  // register port
  input wire [3:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // state
  output reg [31:0] ACC_O,
  output reg TEST_FLAG_O,
  output reg DONE_O,
  output reg IRQ_O
);
  reg [31:0] main_result_reg;
  reg flag_n;
  reg flag_z;
  reg flag_c;
  reg flag_v;
  reg test_flag;
  reg saturate_mode_bit;
  reg object_code_mode;
  reg [15:0] repeat_count_reg;
  reg [`AMU_EV_W-1:0] status;
  reg [`AMU_EV_W-1:0] mask;
  reg [31:0] next_acc;
  reg [`AMU_EV_W-1:0] events;
  reg [31:0] next_rdata;
  wire is_abs;
  wire is_magnitude_toggle_sign_op;
  wire illegal;
  wire [31:0] mag;
  wire ovf;
  wire neg_in;
  wire exec;
  wire [`AMU_EV_W-1:0] next_status;

  amu_decode u_decode
  (
    .opcode_i(OPCODE_I),
    .valid_i(INSTR_VALID_I),
    .native_mode_i(object_code_mode),
    .is_abs_o(is_abs),
    .is_magnitude_toggle_sign_op_o(is_magnitude_toggle_sign_op),
    .illegal_o(illegal)
  );

  amu_magnitude #(.WIDTH(32)) u_mag
  (
    .value_i(main_result_reg),
    .saturate_i(saturate_mode_bit),
    .result_o(mag),
    .overflow_o(ovf),
    .negative_in_o(neg_in)
  );

  assign exec = is_abs || is_magnitude_toggle_sign_op;

  // events raised this cycle
  always @*
  begin
    events = {`AMU_EV_W{1'b0}};
    events[`AMU_EV_ABS] = is_abs;
    events[`AMU_EV_MAGNITUDE_TOGGLE_SIGN_OP] = is_magnitude_toggle_sign_op;
    events[`AMU_EV_OVF] = exec && ovf;
    events[`AMU_EV_RPT] = exec && (repeat_count_reg != 16'h0000);
    events[`AMU_EV_ILLEGAL] = illegal;
  end

  // set beats write-one-to-clear
  assign next_status = (WR_I && ADDR_I == `AMU_REG_STATUS) ?
    ((status & ~WDATA_I[`AMU_EV_W-1:0]) | events) : (status | events);

  // accumulator source: instruction result or software write
  always @*
  begin
    next_acc = main_result_reg;
    if (exec)
      next_acc = mag;
    else if (WR_I && ADDR_I == `AMU_REG_ACC)
      next_acc = WDATA_I;
  end

  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      main_result_reg <= `AMU_ACC_RESET;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      flag_v <= 1'b0;
      test_flag <= 1'b0;
      saturate_mode_bit <= 1'b0;
      object_code_mode <= 1'b0;
      repeat_count_reg <= 16'h0000;
      status <= {`AMU_EV_W{1'b0}};
      mask <= {`AMU_EV_W{1'b0}};
    end
    else
    begin
      main_result_reg <= next_acc;
      status <= next_status;
      if (WR_I && ADDR_I == `AMU_REG_MODE)
      begin
        saturate_mode_bit <= WDATA_I[0];
        object_code_mode <= WDATA_I[1];
      end
      if (WR_I && ADDR_I == `AMU_REG_MASK)
        mask <= WDATA_I[`AMU_EV_W-1:0];
      if (exec)
      begin
        flag_n <= mag[`AMU_SIGN_BIT];
        flag_z <= (mag == 32'h00000000);
        flag_c <= 1'b0;
        if (ovf)
          flag_v <= 1'b1;
        if (is_magnitude_toggle_sign_op && neg_in)
          test_flag <= ~test_flag;
        repeat_count_reg <= 16'h0000;
      end
      else
      begin
        if (WR_I && ADDR_I == `AMU_REG_FLAGS)
        begin
          flag_n <= WDATA_I[`AMU_F_N];
          flag_z <= WDATA_I[`AMU_F_Z];
          flag_c <= WDATA_I[`AMU_F_C];
          flag_v <= WDATA_I[`AMU_F_V];
          test_flag <= WDATA_I[`AMU_F_TC];
        end
        if (WR_I && ADDR_I == `AMU_REG_RPT)
          repeat_count_reg <= WDATA_I[15:0];
      end
    end
  end

  // read mux
  always @*
  begin
    case (ADDR_I)
      `AMU_REG_ACC: next_rdata = main_result_reg;
      `AMU_REG_FLAGS: next_rdata = {27'h0000000, test_flag, flag_v, flag_c, flag_z, flag_n};
      `AMU_REG_MODE: next_rdata = {30'h00000000, object_code_mode, saturate_mode_bit};
      `AMU_REG_RPT: next_rdata = {16'h0000, repeat_count_reg};
      `AMU_REG_STATUS: next_rdata = {27'h0000000, status};
      `AMU_REG_MASK: next_rdata = {27'h0000000, mask};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // registered outputs
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      RDATA_O <= 32'h00000000;
      ACC_O <= `AMU_ACC_RESET;
      TEST_FLAG_O <= 1'b0;
      DONE_O <= 1'b0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      RDATA_O <= RD_I ? next_rdata : 32'h00000000;
      ACC_O <= next_acc;
      TEST_FLAG_O <= (exec && is_magnitude_toggle_sign_op && neg_in) ? ~test_flag : test_flag;
      DONE_O <= exec;
      IRQ_O <= |(next_status & mask);
    end
  end
endmodule // amu_top

// *** verif/amu_chk.sv ***
// assertions on the magnitude unit ports
// assumes binding onto amu_top
`timescale 1ns/10ps
module amu_chk
(
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // observed
  input wire INSTR_VALID_I,
  input wire [15:0] OPCODE_I,
  input wire [31:0] ACC_O,
  input wire TEST_FLAG_O,
  input wire DONE_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  wire pl = INSTR_VALID_I && OPCODE_I == 16'hff56;
  wire tg = INSTR_VALID_I && OPCODE_I == 16'h565f;
  wire mn = ACC_O == 32'h80000000;
  a_plain_done: assert property (pl |=> DONE_O)
    else $error("plain op not done");
  a_idle_quiet: assert property (!INSTR_VALID_I |=> !DONE_O)
    else $error("done without op");
  a_other_refused: assert property (INSTR_VALID_I && !pl && !tg |=> !DONE_O)
    else $error("foreign opcode done");
  a_neg_negated: assert property ((pl || tg) && ACC_O[31] && !mn ##1 DONE_O |-> ACC_O == -$past(ACC_O))
    else $error("negative not negated");
  a_pos_kept: assert property ((pl || tg) && !ACC_O[31] |=> $stable(ACC_O))
    else $error("positive changed");
  a_min_result: assert property ((pl || tg) && mn |=> (ACC_O == 32'h7fffffff || mn))
    else $error("bad most negative result");
  a_tc_toggle: assert property (tg ##1 DONE_O |-> TEST_FLAG_O == ($past(TEST_FLAG_O) ^ $past(ACC_O[31])))
    else $error("test flag wrong");
  a_tc_plain: assert property (pl |=> $stable(TEST_FLAG_O))
    else $error("plain op moved test flag");
  cover property (pl && mn ##1 ACC_O == 32'h7fffffff);
  cover property (tg ##1 DONE_O);
  cover property (tg ##1 !DONE_O);
endmodule // amu_chk
bind amu_top amu_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .INSTR_VALID_I(INSTR_VALID_I),
  .OPCODE_I(OPCODE_I), .ACC_O(ACC_O), .TEST_FLAG_O(TEST_FLAG_O), .DONE_O(DONE_O));

// *** verif/amu_top_test.sv ***
// bench for amu_top: integer model compared at every result
// assumes the register map and one-cycle timing of the core port
`timescale 1ns/10ps
module amu_top_test;
  logic clk = 0, rst = 1, vld = 0, wr = 0, rd = 0, x;
  logic [15:0] opc = 0, m_rp;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, rdat, acc, m_acc;
  logic [4:0] m_fl, m_st = 0;
  logic [1:0] m_md;
  wire tc, done, irq;
  int err_count = 0, check_count = 0;
  always #4 clk = ~clk;
  amu_top dut (.CLK_I(clk), .RST_I(rst), .INSTR_VALID_I(vld), .OPCODE_I(opc),
    .ADDR_I(adr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .ACC_O(acc),
    .TEST_FLAG_O(tc), .DONE_O(done), .IRQ_O(irq));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(logic [3:0] a, logic [31:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("reg", rdat, e);
    @(posedge clk);
    #1 chk("rdat idle", rdat, 0);
  endtask
  task automatic op(logic [15:0] o);
    logic ng;
    ng = m_acc[31];
    x = o == 16'hff56 || m_md[1];
    m_st[4] |= !x;
    if (x)
    begin
      m_st[o[0]] = 1;
      m_st[2] |= m_acc == 32'h80000000;
      m_st[3] |= m_rp != 0;
      m_fl[3] |= m_acc == 32'h80000000;
      m_acc = m_acc == 32'h80000000 ? (m_md[0] ? 32'h7fffffff : m_acc) : (ng ? -m_acc : m_acc);
      m_fl[4] ^= ng & o[0];
      m_fl[2:0] = {1'b0, m_acc == 0, m_acc[31]};
      m_rp = 0;
    end
    @(posedge clk);
    opc <= o;
    vld <= 1;
    @(posedge clk);
    vld <= 0;
    #1 chk("done", done, x);
    chk("acc", acc, m_acc);
    chk("tc", tc, m_fl[4]);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    void'($urandom(80778));
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int a = 0; a < 3; a++)
      rreg(4'(a), 0);
    rreg(4'hf, 0);
    $display("reset test done");
    for (int i = 0; i < 60; i++)
    begin
      // first eight: zero, most negative, max positive, minus one
      m_acc = i < 8 ? {i[1], {31{i[2]}}} : $urandom;
      m_md = i < 8 ? {1'b1, i[0]} : 2'($urandom);
      m_fl = 5'($urandom);
      m_rp = 16'($urandom_range(0, 2));
      wreg(0, m_acc);
      wreg(1, 32'(m_fl));
      wreg(2, 32'(m_md));
      wreg(3, 32'(m_rp));
      op(i[0] ? 16'h565f : 16'hff56);
      rreg(1, 32'(m_fl));
      rreg(3, 32'(m_rp));
    end
    $display("magnitude test done");
    rreg(4, 32'(m_st));
    chk("irq", irq, 0);
    wreg(5, 32'h1f);
    @(posedge clk);
    #1 chk("irq", irq, 32'(|m_st));
    wreg(4, 32'h1f);
    @(posedge clk);
    #1 chk("irq", irq, 0);
    rreg(4, 0);
    $display("interrupt test done");
    results;
  end
endmodule // amu_top_test
